// ---- core/pfm_pkg.sv ----
// Shared constants and types for the pin function merge block
package pfm_pkg;
    // Pin and function counts
    localparam int PIN_CNT = 16;
    localparam int OR_FN_CNT = 4;
    localparam int AND_FN_CNT = 4;
    localparam int OUT_FN_CNT = 4;
    localparam int AXI_AW = 12;
    // Fixed roles of two AND-type input functions
    localparam int AND_FN_BUS_REQ = 2;
    localparam int AND_FN_WAIT = 3;
    // Configuration register offsets (byte addresses)
    localparam logic [11:0] OFS_OR_SEL = 12'h000;
    localparam logic [11:0] OFS_AND_SEL = 12'h010;
    localparam logic [11:0] OFS_OUT_SEL = 12'h020;
    localparam logic [11:0] OFS_ADDR_SEL = 12'h030;
    localparam logic [11:0] OFS_DATA_SEL = 12'h034;
    localparam logic [11:0] OFS_CTRL_SEL = 12'h038;
    localparam logic [11:0] OFS_MERGED = 12'h03C;
    localparam int CFG_WORDS = 15;
    // Port level register: printed offset is an index, byte address is four times it
    localparam logic [31:0] IDX_PORT_LEVELS = 32'hFFFFD382;
    localparam logic [11:0] OFS_PORT_LEVELS = 12'(IDX_PORT_LEVELS * 32'h4);
    // Reset values
    localparam logic [15:0] RST_SEL = 16'h0000;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Per-pin drive bundle
    typedef struct packed {
        logic [PIN_CNT-1:0] out;
        logic [PIN_CNT-1:0] oe;
    } pfm_pin_drive_t;
    // Merged input function results
    typedef struct packed {
        logic [OR_FN_CNT-1:0] or_fn;
        logic [AND_FN_CNT-1:0] and_fn;
    } pfm_merged_t;
endpackage

// ---- core/pfm_sync2.sv ----
// Two-stage synchroniser for pin levels
`timescale 1ns/1ns
`default_nettype none
module pfm_sync2 #(
    parameter int WIDTH = 16
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [WIDTH-1:0] async_in, // Levels from pins
    output logic [WIDTH-1:0] sync_out // Levels in clock domain
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // First stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_out = stage2_ff;
endmodule // pfm_sync2
`default_nettype wire

// ---- core/pfm_top.sv ----
// Pin function merge logic, bus-pin forcing and input-only port
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Multi-pin serial and capture inputs merge by OR
// - Multi-pin interrupt, request, trigger inputs merge by AND
// - Output function drives each selected pin not claimed by a bus function or a lower-numbered output function
// - Low port pin switched to request gives edge
// - Single-chip: address pins drive static level
// - Single-chip: data pins left high impedance
// - Single-chip: other bus outputs held high
// - Single-chip: bus request and wait ignored
// - Bus request and wait pins stay inputs
// - Input port has 8 or 16 pins
// - Port register 16 bits, read-only, bit n pin n
// - Only implemented pins map to register bits
// - Writes to port register are discarded
// - Reads return live pin levels
// - Converter-sampled pin reads as one
module pfm_top #(
    parameter int PORT_WIDTH = 16, // 8 or 16 port pins
    parameter logic ADDR_STATIC_LEVEL = 1'b0 // Level on address pins in single-chip mode
) (
    input wire logic aclk, // System clock, 100 MHz
    input wire logic aresetn, // Synchronous reset, active low
    // AXI4-Lite slave
    input wire logic [pfm_pkg::AXI_AW-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [pfm_pkg::AXI_AW-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    // Operating mode
    input wire logic single_chip_mode, // High in single-chip mode
    // Multiplexed pins
    input wire logic [pfm_pkg::PIN_CNT-1:0] mux_pin_in, // Pin levels
    output logic [pfm_pkg::PIN_CNT-1:0] mux_pin_out, // Pin output values
    output logic [pfm_pkg::PIN_CNT-1:0] mux_pin_oe, // Pin output enables
    // Bus controller drive per pin, used outside single-chip mode
    input wire pfm_pkg::pfm_pin_drive_t bus_drive, // Bus pin values and enables
    // Output function values from peripherals
    input wire logic [pfm_pkg::OUT_FN_CNT-1:0] out_fn_value, // Output function levels
    // Merged input functions to peripherals
    output pfm_pkg::pfm_merged_t merged_fn, // Merged input function levels
    output logic [pfm_pkg::AND_FN_CNT-1:0] and_fn_fall, // Falling edge pulses of AND functions
    // Input-only port
    input wire logic [15:0] port_pin_in, // Port pin levels
    input wire logic [15:0] adc_sampling // Converter sampling each pin
);
    localparam int NP = pfm_pkg::PIN_CNT;
    localparam int NOR = pfm_pkg::OR_FN_CNT;
    localparam int NAND = pfm_pkg::AND_FN_CNT;
    localparam int NOUT = pfm_pkg::OUT_FN_CNT;
    localparam int AW = pfm_pkg::AXI_AW;

    // Byte-strobe merge of a write into a 16-bit register
    function automatic logic [15:0] strb_merge(input logic [15:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // Configuration word index of an address, CFG_WORDS when none
    function automatic logic [3:0] cfg_index(input logic [AW-1:0] addr);
        logic [3:0] idx;
        idx = 4'(pfm_pkg::CFG_WORDS);
        if (addr[AW-1:6] == '0 && addr[1:0] == 2'h0 && 32'(addr[5:2]) < pfm_pkg::CFG_WORDS) begin
            idx = addr[5:2];
        end
        return idx;
    endfunction

    // Registers
    logic [15:0] cfg_ff [pfm_pkg::CFG_WORDS];
    logic [AW-1:0] awaddr_ff;
    logic aw_held_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic w_held_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    pfm_pkg::pfm_merged_t merged_ff;
    logic [NAND-1:0] fall_ff;
    logic [NP-1:0] pin_out_ff;
    logic [NP-1:0] pin_oe_ff;

    // Synchronised pin levels
    logic [NP-1:0] pin_sync;
    logic [15:0] port_sync;

    pfm_sync2 #(.WIDTH(NP)) u_sync_mux (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(mux_pin_in),
        .sync_out(pin_sync)
    );

    pfm_sync2 #(.WIDTH(16)) u_sync_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(port_pin_in),
        .sync_out(port_sync)
    );

    // Named views of the configuration words
    logic [NP-1:0] addr_sel;
    logic [NP-1:0] data_sel;
    logic [NP-1:0] ctrl_sel;
    assign addr_sel = cfg_ff[12];
    assign data_sel = cfg_ff[13];
    assign ctrl_sel = cfg_ff[14];

    // OR-type merge: unselected pins contribute 0
    logic [NOR-1:0] or_merge;
    genvar gi;
    generate
        for (gi = 0; gi < NOR; gi++) begin : g_or
            assign or_merge[gi] = |(pin_sync & cfg_ff[gi]);
        end
    endgenerate

    // AND-type merge: unselected pins contribute 1
    logic [NAND-1:0] and_raw;
    logic [NAND-1:0] and_merge;
    generate
        for (gi = 0; gi < NAND; gi++) begin : g_and
            assign and_raw[gi] = &(pin_sync | ~cfg_ff[NOR+gi]);
            if (gi == pfm_pkg::AND_FN_BUS_REQ || gi == pfm_pkg::AND_FN_WAIT) begin : g_bus_in
                // Pins still sampled as inputs, result held inactive in single-chip mode
                assign and_merge[gi] = and_raw[gi] | single_chip_mode;
            end else begin : g_plain
                assign and_merge[gi] = and_raw[gi];
            end
        end
    endgenerate

    // Selecting a low pin turns the merged level 1 to 0, seen as a falling edge
    logic [NAND-1:0] fall_det;
    assign fall_det = merged_ff.and_fn & ~and_merge;

    // Output function per pin: lowest selecting function wins
    logic [NP-1:0] fn_hit;
    logic [NP-1:0] fn_val;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_fn
            logic [NOUT-1:0] sel_col;
            logic [NOUT-1:0] first_col;
            for (genvar fk = 0; fk < NOUT; fk++) begin : g_col
                assign sel_col[fk] = cfg_ff[NOR+NAND+fk][gi];
            end
            assign first_col = sel_col & (~sel_col + NOUT'(1));
            assign fn_hit[gi] = |sel_col;
            assign fn_val[gi] = |(first_col & out_fn_value);
        end
    endgenerate

    // Pin drive selection: bus functions first, then output functions
    logic [NP-1:0] nxt_pin_out;
    logic [NP-1:0] nxt_pin_oe;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_drv
            assign nxt_pin_oe[gi] = data_sel[gi] ? (!single_chip_mode && bus_drive.oe[gi]) :
                                    (addr_sel[gi] | ctrl_sel[gi]) ?
                                    (single_chip_mode | bus_drive.oe[gi]) : fn_hit[gi];
            assign nxt_pin_out[gi] = data_sel[gi] ? (!single_chip_mode && bus_drive.out[gi]) :
                                     addr_sel[gi] ? (single_chip_mode ? ADDR_STATIC_LEVEL :
                                                     bus_drive.out[gi]) :
                                     ctrl_sel[gi] ? (single_chip_mode | bus_drive.out[gi]) :
                                     (fn_hit[gi] & fn_val[gi]);
        end
    endgenerate

    // Input port read value: live levels, converter-sampled pins read 1
    logic [15:0] port_live;
    logic [15:0] port_mask;
    logic [15:0] port_read;
    assign port_mask = (PORT_WIDTH == 8) ? 16'h00FF : 16'hFFFF;
    assign port_live = port_sync | adc_sampling;
    assign port_read = port_live & port_mask;

    // Write path decode
    logic wr_go;
    logic [3:0] wr_idx;
    logic wr_cfg;
    logic wr_port;
    logic wr_ok;
    logic [3:0] wr_slot;
    assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_idx = cfg_index(awaddr_ff);
    assign wr_cfg = wr_go && (32'(wr_idx) < pfm_pkg::CFG_WORDS);
    assign wr_port = awaddr_ff == pfm_pkg::OFS_PORT_LEVELS;
    assign wr_ok = (32'(wr_idx) < pfm_pkg::CFG_WORDS) || wr_port
                   || awaddr_ff == pfm_pkg::OFS_MERGED;

    // Array index kept in range when the address decodes to no word
    assign wr_slot = wr_cfg ? wr_idx : 4'h0;

    // Read path decode
    logic rd_go;
    logic [3:0] rd_idx;
    logic rd_cfg;
    logic rd_port;
    logic rd_merged;
    logic [31:0] rd_word;
    logic [3:0] rd_slot;
    assign rd_go = s_axi_arvalid && !rvalid_ff;
    assign rd_idx = cfg_index(s_axi_araddr);
    assign rd_cfg = 32'(rd_idx) < pfm_pkg::CFG_WORDS;
    assign rd_port = s_axi_araddr == pfm_pkg::OFS_PORT_LEVELS;
    assign rd_merged = s_axi_araddr == pfm_pkg::OFS_MERGED;

    // Array index kept in range for unmapped reads
    assign rd_slot = rd_cfg ? rd_idx : 4'h0;
    assign rd_word = rd_port ? {16'h0000, port_read} :
                     rd_merged ? {24'h00_0000, merged_ff} :
                     rd_cfg ? {16'h0000, cfg_ff[rd_slot]} : pfm_pkg::RST_RDATA;

    // Handshake outputs
    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready = !w_held_ff;
    assign s_axi_arready = !rvalid_ff;

    // Response channels straight from registers
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    // Write address and data capture, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (s_axi_awvalid && !aw_held_ff) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_ff <= 1'b0;
            end
            if (s_axi_wvalid && !w_held_ff) begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    // Write response; the port register takes no write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= pfm_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? pfm_pkg::RESP_OKAY : pfm_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Configuration words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < pfm_pkg::CFG_WORDS; i++) begin
                cfg_ff[i] <= pfm_pkg::RST_SEL;
            end
        end else if (wr_cfg) begin
            cfg_ff[wr_slot] <= strb_merge(cfg_ff[wr_slot], wdata_ff, wstrb_ff);
        end
    end

    // Read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= pfm_pkg::RESP_OKAY;
            rdata_ff <= pfm_pkg::RST_RDATA;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= (rd_cfg || rd_port || rd_merged) ? pfm_pkg::RESP_OKAY : pfm_pkg::RESP_SLVERR;
            rdata_ff <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Merged levels and edge pulses; reset levels match idle, so no false edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            merged_ff <= {{NOR{1'b0}}, {NAND{1'b1}}};
            fall_ff <= '0;
        end else begin
            merged_ff <= {or_merge, and_merge};
            fall_ff <= fall_det;
        end
    end

    // Pin drive registers; every pin released while in reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
        end
    end

    assign merged_fn = merged_ff;
    assign and_fn_fall = fall_ff;
    assign mux_pin_out = pin_out_ff;
    assign mux_pin_oe = pin_oe_ff;
endmodule // pfm_top
`default_nettype wire

// ---- tb/pfm_properties.sv ----
// Port-level assertions for the pin function merge block
`timescale 1ns/1ns
`default_nettype none
module pfm_checker #(
    parameter int PORT_WIDTH = 16
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic s_axi_awvalid, // Watched
    input wire logic s_axi_awready, // Watched
    input wire logic s_axi_wvalid, // Watched
    input wire logic s_axi_wready, // Watched
    input wire logic [1:0] s_axi_bresp, // Watched
    input wire logic s_axi_bvalid, // Watched
    input wire logic s_axi_bready, // Watched
    input wire logic [pfm_pkg::AXI_AW-1:0] s_axi_araddr, // Watched
    input wire logic s_axi_arvalid, // Watched
    input wire logic s_axi_arready, // Watched
    input wire logic [31:0] s_axi_rdata, // Watched
    input wire logic [1:0] s_axi_rresp, // Watched
    input wire logic s_axi_rvalid, // Watched
    input wire logic s_axi_rready, // Watched
    input wire logic single_chip_mode, // Watched
    input wire pfm_pkg::pfm_merged_t merged_fn, // Watched
    input wire logic [pfm_pkg::AND_FN_CNT-1:0] and_fn_fall, // Watched
    input wire logic [15:0] port_pin_in, // Watched
    input wire logic [15:0] adc_sampling // Watched
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Read of the port level register taken at this edge
    wire logic ar_port = s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == pfm_pkg::OFS_PORT_LEVELS;
    AST_PORT_LIVE: assert property (ar_port && $past(aresetn) && $past(aresetn, 2) |=>
        s_axi_rdata[PORT_WIDTH-1:0] == ($past(port_pin_in[PORT_WIDTH-1:0], 3) | $past(adc_sampling[PORT_WIDTH-1:0])))
        else $error("port read value wrong");
    AST_PORT_UPPER: assert property (ar_port |=>
        s_axi_rdata[31:PORT_WIDTH] == '0 && s_axi_rresp == pfm_pkg::RESP_OKAY)
        else $error("port read upper bits or response wrong");
    AST_AND_FALL: assert property (
        and_fn_fall == ($past(merged_fn.and_fn) & ~merged_fn.and_fn))
        else $error("fall pulse does not match merged level");
    AST_SC_IGNORE: assert property ($past(single_chip_mode) |->
        merged_fn.and_fn[pfm_pkg::AND_FN_BUS_REQ] && merged_fn.and_fn[pfm_pkg::AND_FN_WAIT])
        else $error("bus request or wait active in single-chip mode");
    // Register bus handshakes
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
        |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_LAT: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
endmodule // pfm_checker
bind pfm_top pfm_checker #(.PORT_WIDTH(PORT_WIDTH)) pfm_checker_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .single_chip_mode(single_chip_mode),
    .merged_fn(merged_fn), .and_fn_fall(and_fn_fall), .port_pin_in(port_pin_in), .adc_sampling(adc_sampling));
`default_nettype wire

// ---- tb/pfm_pins_model.sv ----
// Board model driving the multiplexed and port pins
`timescale 1ns/1ns
`default_nettype none
module pfm_pins_model (
    input wire logic aclk, // Clock
    input wire logic [15:0] board_lvl, // Board level per pin
    input wire logic [15:0] port_lvl, // Port pin levels
    input wire logic [15:0] mux_pin_out, // Device pin values
    input wire logic [15:0] mux_pin_oe, // Device pin enables
    output logic [15:0] mux_pin_in, // Resolved pin levels
    output var logic [15:0] port_pin_in // Port pin levels
);
    logic [15:0] board_ff;
    // Board changes just after the edge; every pin always held at a level
    always_ff @(posedge aclk) begin
        board_ff <= board_lvl;
        port_pin_in <= port_lvl;
    end
    // Device drive wins where enabled
    assign mux_pin_in = (mux_pin_oe & mux_pin_out) | (~mux_pin_oe & board_ff);
endmodule // pfm_pins_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the pin function merge block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module testbench;
    logic aclk = 1'h0, aresetn = 1'h0, single_chip_mode = 1'h0, snap = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, out_fn_value = 4'h0, and_fn_fall;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] mux_pin_in, mux_pin_out, mux_pin_oe, port_pin_in, adc_sampling = 16'h0;
    logic [15:0] board_lvl = 16'h0, port_lvl = 16'h0, lf = 16'h0014, p, a, o, m;
    pfm_pkg::pfm_pin_drive_t bus_drive = 32'h0;
    pfm_pkg::pfm_merged_t merged_fn;
    logic [33:0] exq[$], e;
    logic [31:0] pq[$];
    int n_errors = 0, checks = 0;
    pfm_top pfm_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .single_chip_mode(single_chip_mode), .mux_pin_in(mux_pin_in), .mux_pin_out(mux_pin_out),
        .mux_pin_oe(mux_pin_oe), .bus_drive(bus_drive), .out_fn_value(out_fn_value), .merged_fn(merged_fn),
        .and_fn_fall(and_fn_fall), .port_pin_in(port_pin_in), .adc_sampling(adc_sampling));
    pfm_pins_model pfm_pins_model_i (.aclk(aclk), .board_lvl(board_lvl), .port_lvl(port_lvl),
        .mux_pin_out(mux_pin_out), .mux_pin_oe(mux_pin_oe), .mux_pin_in(mux_pin_in), .port_pin_in(port_pin_in));
    // 100 MHz clock
    always #5 aclk = ~aclk;
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Merged status from pin levels: OR pairs 0..7, AND pairs 8..15
    function automatic logic [33:0] st(input logic [15:0] w, input logic sc);
        logic [7:0] s;
        for (int i = 0; i < 4; i++) begin
            s[4+i] = |(w & (16'h0003 << (2 * i)));
            s[i] = &(w | ~(16'h0300 << (2 * i)));
        end
        if (sc) s[3:2] = 2'h3;
        return {pfm_pkg::RESP_OKAY, 24'h0, s};
    endfunction
    task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] r);
        exq.push_back({r, 32'h0});
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        // Each channel released at the edge where it is taken
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [33:0] ex);
        exq.push_back(ex);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic snap_pins(input logic [31:0] ex);
        pq.push_back(ex);
        snap <= 1'h1;
        @(posedge aclk);
        snap <= 1'h0;
    endtask
    // Compares each response and pin snapshot with the oldest note
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            e = exq.pop_front();
            `CHK("read", e, {s_axi_rresp, s_axi_rdata})
        end
        if (s_axi_bvalid && s_axi_bready) begin
            e = exq.pop_front();
            `CHK("write", e, {s_axi_bresp, 32'h0})
        end
        if (snap) begin
            e = {2'h0, pq.pop_front()};
            `CHK("pins", e, {2'h0, mux_pin_oe, mux_pin_out & mux_pin_oe})
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0 && exq.size() == 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        report_and_stop();
    end
    // Test sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(pfm_pkg::OFS_OR_SEL, 34'h0);
        rd(pfm_pkg::OFS_MERGED, {pfm_pkg::RESP_OKAY, 32'h0000000F});
        rd(12'h100, {pfm_pkg::RESP_SLVERR, 32'h0});
        wr(12'h100, 32'h0, pfm_pkg::RESP_SLVERR);
        $display("register test done");
        for (int k = 0; k < 6; k++) begin
            p = nx(lf);
            lf = nx(p);
            a = lf & 16'h0F0F;
            port_lvl <= p;
            adc_sampling <= a;
            repeat (4) @(posedge aclk);
            rd(pfm_pkg::OFS_PORT_LEVELS, {18'h0, p | a});
            wr(pfm_pkg::OFS_PORT_LEVELS, {16'h0, ~p}, pfm_pkg::RESP_OKAY);
            rd(pfm_pkg::OFS_PORT_LEVELS, {18'h0, p | a});
        end
        adc_sampling <= 16'h0;
        $display("port test done");
        for (int i = 0; i < 4; i++) begin
            wr(pfm_pkg::OFS_OR_SEL + 12'(4 * i), 32'h3 << (2 * i), pfm_pkg::RESP_OKAY);
            wr(pfm_pkg::OFS_AND_SEL + 12'(4 * i), 32'h300 << (2 * i), pfm_pkg::RESP_OKAY);
            rd(pfm_pkg::OFS_AND_SEL + 12'(4 * i), {2'h0, 32'h300 << (2 * i)});
        end
        for (int k = 0; k < 6; k++) begin
            lf = nx(lf);
            board_lvl <= lf;
            repeat (5) @(posedge aclk);
            rd(pfm_pkg::OFS_MERGED, st(lf, 1'h0));
        end
        board_lvl <= 16'h0;
        $display("merge test done");
        wr(pfm_pkg::OFS_OUT_SEL, 32'h0011, pfm_pkg::RESP_OKAY);
        wr(pfm_pkg::OFS_OUT_SEL + 12'h004, 32'h0100, pfm_pkg::RESP_OKAY);
        wr(pfm_pkg::OFS_ADDR_SEL, 32'h1000, pfm_pkg::RESP_OKAY);
        wr(pfm_pkg::OFS_DATA_SEL, 32'h2000, pfm_pkg::RESP_OKAY);
        wr(pfm_pkg::OFS_CTRL_SEL, 32'h4000, pfm_pkg::RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            p = nx(lf);
            lf = nx(p);
            out_fn_value <= p[3:0];
            bus_drive <= {lf, 16'hFFFF};
            single_chip_mode <= k[1];
            repeat (5) @(posedge aclk);
            m = k[1] ? 16'h5111 : 16'h7111;
            o = {1'h0, k[1] ? 3'h4 : lf[14:12], 3'h0, p[1], 3'h0, p[0], 3'h0, p[0]} & m;
            snap_pins({m, o});
            rd(pfm_pkg::OFS_MERGED, st(o, k[1]));
        end
        $display("pin test done");
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
